// ===== blink_if.sv
// blink timing carried from the shared timer to the indicator logic
`timescale 1ns/1ps
interface blink_if;
    logic phase;  // high in the lit half of a blink period
    logic tick;   // one-cycle pulse at each half-period boundary
    modport source (output phase, output tick);
    modport sink (input phase, input tick);
endinterface

// ===== blink_timer.sv
// shared blink-rate timer for every flashing indicator
`timescale 1ns/1ps
module blink_timer #(
    parameter int HALF_CYCLES = panel_led_pkg::BLINK_HALF_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // blink timing out
    blink_if.source blink
);
    import panel_led_pkg::*;

    logic [31:0] count;       // cycles into the current half period
    logic [31:0] next_count;
    logic phase;              // lit half flag
    logic next_phase;
    logic tick;               // boundary pulse
    logic next_tick;

    // ==========================================================
    // next values
    // ==========================================================
    // one counter for all leds keeps every blink in step
    always_comb begin
        next_count = count + 32'h1;
        next_phase = phase;
        next_tick = 1'b0;
        if (count >= 32'(HALF_CYCLES - 1)) begin
            next_count = 32'h0;
            next_phase = ~phase;
            next_tick = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 32'h0;
            phase <= 1'b1;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            phase <= next_phase;
            tick <= next_tick;
        end
    end

    assign blink.phase = phase;
    assign blink.tick = tick;
endmodule

// ===== led_viewer.sv
// operator view: colours and dark spells each led showed
`timescale 1ns/1ps
module led_viewer (
    // clock, reset and window restart
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clear,
    // six leds, two bits each
    input wire logic [11:0] leds,
    // lit, dark and last lit colour seen in the window
    output logic [5:0] seen_on,
    output logic [5:0] seen_off,
    output logic [11:0] lit_color
);
    // the eye samples once a clock, so a blink shows lit and dark
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n || clear) begin
            {seen_on, seen_off, lit_color} <= 24'h000000;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (leds[2*i+:2] != 2'h0) begin
                    seen_on[i] <= 1'h1;
                    lit_color[2*i+:2] <= leds[2*i+:2];
                end else begin
                    seen_off[i] <= 1'h1;
                end
            end
        end
    end
endmodule

// ===== panel_led_asserts.sv
// assertion checker for the panel status indicator logic
`timescale 1ns/1ps
module panel_led_asserts #(
    parameter int SELFTEST = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register writes
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // status and handshakes
    input wire logic power_good,
    input wire logic link_err,
    input wire logic laser_on,
    input wire logic button_press,
    input wire logic button_action,
    input wire logic cfg_load_req,
    input wire logic cfg_load_done,
    // leds
    input wire panel_led_pkg::led_color_type power_alive_led,
    input wire panel_led_pkg::led_color_type link_led,
    input wire panel_led_pkg::led_color_type enc_led,
    input wire panel_led_pkg::led_color_type slot_a_led,
    input wire panel_led_pkg::led_color_type slot_b_led,
    input wire panel_led_pkg::led_color_type laser_led
);
    import panel_led_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ==========
    // shadow state
    // ==========
    logic dark, lock; // copies of the control bits
    logic acked; // a locked press may now flash the front leds
    logic loaded; // boot reached normal operation
    int cyc; // edges since reset release, saturating
    // shadows update on the same edge as the real registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {dark, lock, acked, loaded} <= 4'h0;
            cyc <= 0;
        end else begin
            if (reg_wr && reg_addr == ADDR_CTRL) begin
                dark <= reg_wdata[CTRL_DARK_BIT];
                lock <= reg_wdata[CTRL_LOCK_BIT];
            end
            acked <= acked || (button_press && lock && loaded);
            loaded <= loaded || (cfg_load_req && cfg_load_done);
            cyc <= (cyc < 1000) ? cyc + 1 : cyc;
        end
    end
    // ==========
    // properties
    // ==========
    property p_dark;
        $past(dark) |-> {power_alive_led, link_led, enc_led, slot_a_led,
            slot_b_led, laser_led} == 12'h000;
    endproperty
    a_dark: assert property (p_dark)
        else $error("led lit in dark mode");
    property p_laser;
        $past(arst_n) && !$past(dark) |->
            laser_led == ($past(laser_on) ? COL_RED : COL_OFF);
    endproperty
    a_laser: assert property (p_laser)
        else $error("laser led wrong");
    property p_unpowered;
        !$past(power_good) |-> power_alive_led == COL_OFF;
    endproperty
    a_unpowered: assert property (p_unpowered)
        else $error("power led lit while unpowered");
    property p_booting;
        cfg_load_req |-> power_alive_led == COL_OFF;
    endproperty
    a_booting: assert property (p_booting)
        else $error("power led lit before run");
    property p_req;
        cfg_load_req |=> cfg_load_req == !$past(cfg_load_done);
    endproperty
    a_req: assert property (p_req)
        else $error("load request not held or not dropped");
    property p_start;
        $rose(cfg_load_req) |-> !loaded && cyc >= SELFTEST - 1 &&
            cyc <= SELFTEST + 3;
    endproperty
    a_start: assert property (p_start)
        else $error("load request at wrong time");
    property p_press;
        $past(button_press && loaded) |-> button_action == !$past(lock);
    endproperty
    a_press: assert property (p_press)
        else $error("button action wrong for lock state");
    property p_link_err;
        $past(link_err) && !acked |-> link_led inside {COL_YELLOW, COL_OFF};
    endproperty
    a_link_err: assert property (p_link_err)
        else $error("link error not shown");
endmodule

// ===== panel_led_logic.sv
// front and rear panel status indicator logic with register port
// ==============================================================
// ==============================================================
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module panel_led_logic #(
    parameter bit IS_RECEIVER = 1'b0,
    parameter int BLINK_HALF = panel_led_pkg::BLINK_HALF_CYCLES,
    parameter int SELFTEST = panel_led_pkg::SELFTEST_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // unit status inputs
    input wire logic power_good,
    input wire logic link_up,
    input wire logic link_err,
    input wire logic enc_on,
    input wire logic enc_err,
    input wire logic input_sel,
    input wire logic [1:0] input_valid,
    input wire logic sig_valid,
    input wire logic sig_err,
    input wire panel_led_pkg::conv_mode_type conv_mode,
    input wire logic laser_on,
    // button and configuration handshake
    input wire logic button_press,
    output logic button_action,
    output logic cfg_load_req,
    input wire logic cfg_load_done,
    // leds
    output panel_led_pkg::led_color_type power_alive_led,
    output panel_led_pkg::led_color_type link_led,
    output panel_led_pkg::led_color_type enc_led,
    output panel_led_pkg::led_color_type slot_a_led,
    output panel_led_pkg::led_color_type slot_b_led,
    output panel_led_pkg::led_color_type laser_led
);
    import panel_led_pkg::*;

    // ==========================================================
    // shared blink timer
    // ==========================================================
    blink_if blink ();

    blink_timer #(
        .HALF_CYCLES(BLINK_HALF)
    ) u_blink (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .blink(blink)
    );

    // ==========================================================
    // boot sequencing
    // ==========================================================
    boot_state_type boot;           // self-test, load, run
    boot_state_type next_boot;
    logic [31:0] st_count;          // self-test elapsed cycles
    logic [31:0] next_st_count;
    logic next_cfg_load_req;
    logic cfg_loaded_evt;           // pulse when run is entered

    // power-up runs the self-test, then asks for the stored setup
    always_comb begin
        next_boot = boot;
        next_st_count = st_count;
        next_cfg_load_req = 1'b0;
        cfg_loaded_evt = 1'b0;
        unique case (boot)
            BOOT_SELFTEST: begin
                next_st_count = st_count + 32'h1;
                if (st_count >= 32'(SELFTEST - 1)) begin
                    next_boot = BOOT_LOAD;
                    next_cfg_load_req = 1'b1;
                end
            end
            BOOT_LOAD: begin
                // request held until the store reports completion
                next_cfg_load_req = ~cfg_load_done;
                if (cfg_load_done) begin
                    next_boot = BOOT_RUN;
                    cfg_loaded_evt = 1'b1;
                end
            end
            BOOT_RUN: begin
                next_boot = BOOT_RUN;
            end
            default: begin
                // corrupted code: restart the whole power-up sequence
                next_boot = BOOT_SELFTEST;
                next_st_count = 32'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            boot <= BOOT_SELFTEST;
            st_count <= 32'h0;
            cfg_load_req <= 1'b0;
        end else begin
            boot <= next_boot;
            st_count <= next_st_count;
            cfg_load_req <= next_cfg_load_req;
        end
    end

    // ==========================================================
    // registers, interrupts and front panel lock
    // ==========================================================
    logic [CTRL_WIDTH-1:0] ctrl;          // dark, lock, out of service
    logic [CTRL_WIDTH-1:0] next_ctrl;
    logic [IRQ_WIDTH-1:0] irq_status;     // sticky events
    logic [IRQ_WIDTH-1:0] next_irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;       // one enables the event
    logic [IRQ_WIDTH-1:0] next_irq_mask;
    logic [IRQ_WIDTH-1:0] irq_set;
    logic [31:0] next_reg_rdata;
    logic [2:0] lock_left;                // lock ack halves remaining
    logic [2:0] next_lock_left;
    logic next_button_action;
    logic link_err_d;                     // for rising edge of errors
    logic enc_err_d;
    logic lock_ack_start;
    logic [11:0] led_view;                // current led colours
    logic dark;
    logic locked;
    logic out_of_service;

    assign dark = ctrl[CTRL_DARK_BIT];
    assign locked = ctrl[CTRL_LOCK_BIT];
    assign out_of_service = ctrl[CTRL_OOS_BIT];
    assign led_view = {laser_led, slot_b_led, slot_a_led,
                       enc_led, link_led, power_alive_led};

    // register writes, read mux, lock ack countdown, event capture
    always_comb begin
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_reg_rdata = 32'h0;
        next_lock_left = lock_left;
        next_button_action = 1'b0;
        lock_ack_start = 1'b0;
        // a press only counts once the unit is running
        if (button_press && boot == BOOT_RUN) begin
            if (locked) begin
                // acknowledge instead of acting
                lock_ack_start = 1'b1;
                next_lock_left = LOCK_ACK_HALVES;
            end else begin
                next_button_action = 1'b1;
            end
        end else if (blink.tick && lock_left != 3'h0) begin
            next_lock_left = lock_left - 3'h1;
        end
        irq_set = '0;
        irq_set[IRQ_CFG_LOADED_BIT] = cfg_loaded_evt;
        irq_set[IRQ_LINK_ERR_BIT] = link_err & ~link_err_d;
        irq_set[IRQ_ENC_ERR_BIT] = enc_err & ~enc_err_d;
        irq_set[IRQ_LOCK_ACK_BIT] = lock_ack_start;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_CTRL: next_ctrl = reg_wdata[CTRL_WIDTH-1:0];
                ADDR_IRQ_MASK: next_irq_mask = reg_wdata[IRQ_WIDTH-1:0];
                ADDR_IRQ_STATUS: begin
                    // write one to clear
                    next_irq_status = irq_status
                                      & ~reg_wdata[IRQ_WIDTH-1:0];
                end
                default: begin
                    // writes elsewhere are dropped
                end
            endcase
        end
        // a new event outranks a clear in the same cycle
        next_irq_status = next_irq_status | irq_set;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL: next_reg_rdata = 32'(ctrl);
                ADDR_STATE: begin
                    next_reg_rdata[STATE_BOOT_LSB +: 3] = boot;
                    next_reg_rdata[STATE_PHASE_BIT] = blink.phase;
                    next_reg_rdata[STATE_LOCK_ACK_BIT] = lock_left != 3'h0;
                end
                ADDR_IRQ_STATUS: next_reg_rdata = 32'(irq_status);
                ADDR_IRQ_MASK: next_reg_rdata = 32'(irq_mask);
                ADDR_LED_VIEW: next_reg_rdata = 32'(led_view);
                default: next_reg_rdata = 32'h0;    // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= CTRL_RESET;
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            reg_rdata <= 32'h0;
            lock_left <= 3'h0;
            button_action <= 1'b0;
            link_err_d <= 1'b0;
            enc_err_d <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            reg_rdata <= next_reg_rdata;
            lock_left <= next_lock_left;
            button_action <= next_button_action;
            link_err_d <= link_err;
            enc_err_d <= enc_err;
        end
    end

    // level interrupt, high while any unmasked event is pending
    assign irq = |(irq_status & irq_mask);

    // ==========================================================
    // indicator colours
    // ==========================================================
    led_color_type next_power, next_link, next_enc;
    led_color_type next_slot_a, next_slot_b, next_laser;

    // blinking leds are dark during the unlit half of the period
    function automatic led_color_type lit(input led_color_type col,
                                          input logic flash,
                                          input logic phase);
        lit = (flash && !phase) ? COL_OFF : col;
    endfunction

    // one decode per led; errors are tested first on purpose
    always_comb begin
        // power-alive indicator
        if (!power_good || boot != BOOT_RUN) begin
            next_power = COL_OFF;
        end else if (out_of_service) begin
            // transmitter shows steady green, receiver stays dark
            next_power = IS_RECEIVER ? COL_OFF : COL_GREEN;
        end else begin
            next_power = lit(COL_GREEN, 1'b1, blink.phase);
        end
        // fiber link
        if (link_err) begin
            next_link = lit(COL_YELLOW, 1'b1, blink.phase);
        end else begin
            next_link = link_up ? COL_GREEN : COL_OFF;
        end
        // encryption
        if (enc_err) begin
            next_enc = lit(COL_YELLOW, 1'b1, blink.phase);
        end else begin
            next_enc = enc_on ? COL_GREEN : COL_OFF;
        end
        if (IS_RECEIVER) begin
            // slot a: signal present
            if (sig_err) begin
                next_slot_a = lit(COL_YELLOW, 1'b1, blink.phase);
            end else begin
                next_slot_a = sig_valid ? COL_GREEN : COL_OFF;
            end
            // slot b: output conversion, unused code stays dark
            unique case (conv_mode)
                CONV_SPLIT: next_slot_b = COL_GREEN;
                CONV_DOWNSAMPLE: next_slot_b = COL_YELLOW;
                default: next_slot_b = COL_OFF;
            endcase
        end else begin
            // slot a: input one, slot b: input two
            if (input_sel == 1'b0) begin
                next_slot_a = lit(COL_GREEN, ~input_valid[0],
                                  blink.phase);
                next_slot_b = input_valid[1] ? COL_YELLOW
                                             : COL_OFF;
            end else begin
                next_slot_a = input_valid[0] ? COL_YELLOW
                                             : COL_OFF;
                next_slot_b = lit(COL_GREEN, ~input_valid[1],
                                  blink.phase);
            end
        end
        // rear laser indicator
        next_laser = laser_on ? COL_RED : COL_OFF;
        // lock acknowledge takes over the front panel
        if (lock_left != 3'h0) begin
            next_power = lit(COL_GREEN, 1'b1, blink.phase);
            next_link = next_power;
            next_enc = next_power;
            next_slot_a = next_power;
            next_slot_b = next_power;
        end
        // dark mode blanks everything, status keeps running
        if (dark) begin
            next_power = COL_OFF;
            next_link = COL_OFF;
            next_enc = COL_OFF;
            next_slot_a = COL_OFF;
            next_slot_b = COL_OFF;
            next_laser = COL_OFF;
        end
    end

    // led outputs come straight from flip-flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_alive_led <= COL_OFF;
            link_led <= COL_OFF;
            enc_led <= COL_OFF;
            slot_a_led <= COL_OFF;
            slot_b_led <= COL_OFF;
            laser_led <= COL_OFF;
        end else begin
            power_alive_led <= next_power;
            link_led <= next_link;
            enc_led <= next_enc;
            slot_a_led <= next_slot_a;
            slot_b_led <= next_slot_b;
            laser_led <= next_laser;
        end
    end
endmodule

// ===== panel_led_pkg.sv
// shared constants and types for the panel status indicator logic
package panel_led_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_HZ = 10_000_000;          // ref_clk rate
    localparam int BLINK_HALF_MS = 250;          // blink half period, ms
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int SELFTEST_MS = 100;            // power-on self-test, ms
    localparam int SELFTEST_CYCLES = SELFTEST_MS * (CLK_HZ / 1000);
    localparam logic [2:0] LOCK_ACK_HALVES = 3'h6; // three green blinks

    // ==========================================================
    // register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATE = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_LED_VIEW = 8'h10;

    // control register fields
    localparam int CTRL_DARK_BIT = 0;
    localparam int CTRL_LOCK_BIT = 1;
    localparam int CTRL_OOS_BIT = 2;
    localparam int CTRL_WIDTH = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // interrupt status / mask fields
    localparam int IRQ_CFG_LOADED_BIT = 0;
    localparam int IRQ_LINK_ERR_BIT = 1;
    localparam int IRQ_ENC_ERR_BIT = 2;
    localparam int IRQ_LOCK_ACK_BIT = 3;
    localparam int IRQ_WIDTH = 4;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // state register fields
    localparam int STATE_BOOT_LSB = 0;    // three one-hot boot bits
    localparam int STATE_PHASE_BIT = 3;
    localparam int STATE_LOCK_ACK_BIT = 4;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [1:0] {
        COL_OFF = 2'h0,
        COL_GREEN = 2'h1,
        COL_YELLOW = 2'h2,
        COL_RED = 2'h3
    } led_color_type;

    typedef enum logic [1:0] {
        CONV_TRANSPARENT = 2'h0,
        CONV_SPLIT = 2'h1,
        CONV_DOWNSAMPLE = 2'h2
    } conv_mode_type;

    typedef enum logic [2:0] {
        BOOT_SELFTEST = 3'h1,
        BOOT_LOAD = 3'h2,
        BOOT_RUN = 3'h4
    } boot_state_type;

endpackage

// ===== tb_panel_led.sv
// self-checking bench for the panel status indicator logic
`timescale 1ns/1ps
module tb;
    import panel_led_pkg::*;
    // ==========
    // signals
    // ==========
    localparam int HALF = 4; // short blink half period keeps runs brief
    localparam int STEST = 8; // short self-test
    logic ref_clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rx_rdata;
    logic power_good = 1'h0, link_up = 1'h0, link_err = 1'h0;
    logic enc_on = 1'h0, enc_err = 1'h0, input_sel = 1'h0, laser_on = 1'h0;
    logic sig_valid = 1'h0, sig_err = 1'h0, button_press = 1'h0;
    logic cfg_load_done = 1'h0, irq, button_action, cfg_load_req;
    logic [1:0] input_valid = 2'h0;
    conv_mode_type conv_mode = CONV_TRANSPARENT;
    led_color_type power_alive_led, link_led, enc_led, slot_a_led;
    led_color_type slot_b_led, laser_led;
    wire [11:0] rx_vec; // receiver leds, same order as tx_vec
    wire [11:0] tx_vec = {laser_led, slot_b_led, slot_a_led, enc_led,
        link_led, power_alive_led};
    logic clear = 1'h0, view_rx = 1'h0; // viewer window and source
    logic [5:0] seen_on, seen_off;
    logic [11:0] lit_color;
    int failures = 0, total_checks = 0, cyc = 0;
    // ==========
    // units under test and viewer
    // ==========
    panel_led_logic #(.BLINK_HALF(HALF), .SELFTEST(STEST)) DUT (.*);
    panel_led_logic #(.IS_RECEIVER(1'h1), .BLINK_HALF(HALF),
        .SELFTEST(STEST)) DUT_RX (.*, .reg_rdata(rx_rdata), .irq(),
        .button_action(), .cfg_load_req(), .power_alive_led(rx_vec[1:0]),
        .link_led(rx_vec[3:2]), .enc_led(rx_vec[5:4]),
        .slot_a_led(rx_vec[7:6]), .slot_b_led(rx_vec[9:8]),
        .laser_led(rx_vec[11:10]));
    led_viewer VIEW (.ref_clk, .arst_n, .clear,
        .leds(view_rx ? rx_vec : tx_vec), .seen_on, .seen_off, .lit_color);
    initial forever #50 ref_clk = ~ref_clk;
    // hang guard: the whole run needs well under 2000 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            final_report();
        end
    end
    // ==========
    // shared tasks
    // ==========
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // strobes drop one cycle before the next access can start
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        tick(1);
        reg_wr <= 1'h0;
        tick(1);
    endtask
    task automatic rchk(string w, logic [7:0] a, logic [31:0] m,
        logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'h1;
        tick(1);
        reg_rd <= 1'h0;
        #1 chk(w, reg_rdata & m, e);
        tick(1);
    endtask
    // settle, then watch one led for two blink periods
    task automatic look(int i, led_color_type c, logic blink);
        tick(3);
        clear <= 1'h1;
        tick(1);
        clear <= 1'h0;
        tick(4 * HALF);
        chk("led lit", seen_on[i], c != COL_OFF);
        chk("led dark", seen_off[i], c == COL_OFF || blink);
        if (c != COL_OFF) chk("led colour", lit_color[2*i+:2], c);
    endtask
    task automatic press(logic exp);
        button_press <= 1'h1;
        tick(1);
        button_press <= 1'h0;
        #1 chk("button action", button_action, exp);
        tick(1);
    endtask
    // ==========
    // scenarios
    // ==========
    task automatic t_boot();
        for (int n = 0; n < 50 && cfg_load_req !== 1'h1; n++) tick(1);
        chk("load request", cfg_load_req, 1'h1);
        look(0, COL_OFF, 1'h0);
        rchk("boot load", ADDR_STATE, 32'h7, 32'h2);
        rchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
        cfg_load_done <= 1'h1;
        tick(1);
        cfg_load_done <= 1'h0;
        tick(1);
        chk("masked irq", irq, 1'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        chk("irq", irq, 1'h1);
        rchk("boot run", ADDR_STATE, 32'h7, 32'h4);
        wr(ADDR_IRQ_STATUS, 32'h1);
        chk("cleared irq", irq, 1'h0);
        $display("boot test done");
    endtask
    task automatic t_tx();
        power_good <= 1'h1;
        look(0, COL_GREEN, 1'h1);
        wr(ADDR_CTRL, 32'h4);
        look(0, COL_GREEN, 1'h0);
        wr(ADDR_CTRL, 32'h0);
        power_good <= 1'h0;
        look(0, COL_OFF, 1'h0);
        {power_good, link_up, enc_on, laser_on} <= 4'hF;
        look(1, COL_GREEN, 1'h0);
        look(2, COL_GREEN, 1'h0);
        look(5, COL_RED, 1'h0);
        {link_err, enc_err} <= 2'h3;
        look(1, COL_YELLOW, 1'h1);
        look(2, COL_YELLOW, 1'h1);
        {link_up, link_err, enc_on, enc_err, laser_on} <= 5'h00;
        look(1, COL_OFF, 1'h0);
        look(2, COL_OFF, 1'h0);
        look(5, COL_OFF, 1'h0);
        $display("transmitter led test done");
    endtask
    // every selection and validity mix for both inputs
    task automatic t_inputs();
        logic sel;
        led_color_type c;
        for (int v = 0; v < 8; v++) begin
            input_sel <= v[2];
            input_valid <= v[1:0];
            for (int k = 0; k < 2; k++) begin
                sel = (v[2] == k[0]);
                c = sel ? COL_GREEN : (v[k] ? COL_YELLOW : COL_OFF);
                look(3 + k, c, sel && !v[k]);
            end
        end
        $display("input led test done");
    endtask
    task automatic t_dark();
        {link_up, enc_on, laser_on, sig_valid} <= 4'hF;
        wr(ADDR_CTRL, 32'h1);
        tick(2);
        chk("tx dark", tx_vec, 12'h000);
        chk("rx dark", rx_vec, 12'h000);
        press(1'h1);
        wr(ADDR_CTRL, 32'h0);
        {link_up, enc_on, laser_on, sig_valid} <= 4'h0;
        $display("dark test done");
    endtask
    task automatic t_rx();
        view_rx <= 1'h1;
        look(0, COL_GREEN, 1'h1);
        sig_valid <= 1'h1;
        look(3, COL_GREEN, 1'h0);
        sig_err <= 1'h1;
        look(3, COL_YELLOW, 1'h1);
        {sig_valid, sig_err} <= 2'h0;
        look(3, COL_OFF, 1'h0);
        conv_mode <= CONV_SPLIT;
        look(4, COL_GREEN, 1'h0);
        conv_mode <= CONV_DOWNSAMPLE;
        look(4, COL_YELLOW, 1'h0);
        conv_mode <= CONV_TRANSPARENT;
        look(4, COL_OFF, 1'h0);
        view_rx <= 1'h0;
        $display("receiver led test done");
    endtask
    // last: the acknowledge flashes would mask later link checks
    task automatic t_lock();
        wr(ADDR_CTRL, 32'h2);
        press(1'h0);
        look(1, COL_GREEN, 1'h1);
        rchk("ack irq", ADDR_IRQ_STATUS, 32'h8, 32'h8);
        tick(4 * HALF);
        rchk("ack over", ADDR_STATE, 32'h10, 32'h0);
        $display("lock test done");
    endtask
    initial begin
        tick(5);
        arst_n <= 1'h1;
        t_boot();
        t_tx();
        t_inputs();
        t_dark();
        t_rx();
        t_lock();
        final_report();
    end
endmodule
bind panel_led_logic panel_led_asserts #(.SELFTEST(SELFTEST)) CHK (.*);
